// file: src/rpc_defines.svh
// Constants for the receipt printer controller: status bit positions, model codes, column counts, timing.
// Assumes a 100 MHz mclk_i; included by bare name from the bus decoder, column buffer and top design files.
// Contract
// (R1) Direction flag reads 1 for host writes, 0 while device presents data.
// (R2) Reading printer status sets the direction flag back to 1 at once.
// (R3) Busy flag is 1 during an operation; host waits for it to clear.
// (R4) Status-available flag is 1 only while printer status may be read.
// (R5) Printer status reports two head-position sensors and the low-paper detector.
// (R6) Motor error sets its bit, stops solenoids and motor until initialize.
// (R7) Initialize acts as reset: blank buffer, pointer left, clear error and interrupt.
// (R8) Status request latches the three sensor inputs into printer status.
// (R9) After a status request other commands are refused until status is read; the code still accepts initialize.
// (R10) Host sends the format command right after initialize.
// (R11) Spacing bit selects one or two dots; two dots for ribbon variants only.
// (R12) Five-bit model field selects one of five printer configurations.
// (R13) Increment command advances the pointer right by its five-bit count.
// (R14) In split mode the pointer stays on its current side; the code wraps it for increments only, so a stored character can cross.
// (R15) Print prints the whole buffer, then blanks every position; the code fires no solenoids for the last column.
// (R16) Other commands are refused while printing.
// (R17) Split variant feed bits choose both, receipt, journal or no feed.
// (R18) Split variant stamp bit 0 feeds receipt 11 lines and fires the stamp.
// (R19) Ribbon variants: feed bit 0 adds a feed; ribbon bit 0 red, 1 black.
// (R20) Slip variant release bit 0 releases the slip; host loads at most 29.
// (R21) Fast feed performs as many line feeds as its four-bit count.
// (R22) Split variant fast-feed side bits choose both, receipt or journal.
// (R23) Each stored character advances the pointer by one column.
// (R24) Host order: initialize, poll, format, poll, load, poll, print.
// (R25) Strobes with chip select low decode to command, data and two status reads.
// (R26) Host checks controller status before each new command or data byte.
// (R27) Interrupt asserts when ready for data, releases after the first byte.
// (R28) Paper jam or solenoid on longer than 20 ms flags a motor error; the code ignores a jam while the sequencer is idle.
// (R29) Command bytes are classified by their leading bits; the rest are operands.
// (R30) Print data is a seven-bit code; the top bit is ignored.
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH
`define RPC_CLK_MHZ 100
`define RPC_BLANK 7'h20
`define RPC_COLS 32
`define RPC_CST_PSR 0
`define RPC_CST_IOB 1
`define RPC_CST_IOM 2
`define RPC_PST_MERR 0
`define RPC_PST_LOWP 5
`define RPC_PST_POS1 6
`define RPC_PST_POS0 7
`define RPC_MODEL_RIB_A 5'h1E
`define RPC_MODEL_RIB_B 5'h1D
`define RPC_MODEL_SPLIT 5'h0B
`define RPC_MODEL_LINE 5'h1B
`define RPC_MODEL_SLIP 5'h17
`define RPC_SPLIT_COLS 14
`define RPC_LINE_COLS 31
`define RPC_SLIP_COLS 29
`define RPC_STAMP_FEEDS 11
`define RPC_SOL_MS 20
`define RPC_SOL_CYC (`RPC_SOL_MS * 1000 * 1000 / 10)
`define RPC_LINE_CYC 16
`define RPC_STAMP_CYC 8
`endif

// file: src/rpc_pkg.sv
// Types shared by the receipt printer controller files.
// Assumes rpc_defines.svh is available on the include path.
package rpc_pkg;
  typedef enum logic [2:0] {
    RPC_C_NONE, RPC_C_INIT, RPC_C_STAT, RPC_C_FMT, RPC_C_INC, RPC_C_PRINT, RPC_C_FAST
  } rpc_cmd_t;
  typedef struct packed {
    logic wr_cmd;
    logic wr_data;
    logic rd_ctl;
    logic rd_prn;
  } rpc_access_t;
  typedef struct packed {
    logic [6:0] solenoid_drives_n;
    logic stamp_drive_n;
    logic ribbon_release_n;
    logic journal_feed_n;
    logic receipt_feed_n;
    logic motor_drive_n;
  } rpc_drive_t;
endpackage

// file: src/rpc_bus_decode.sv
// Host strobe synchroniser and access decoder for the receipt printer controller.
// Assumes asynchronous host pins; each access is reported once, at strobe release.
`timescale 1ns/10ps
`include "rpc_defines.svh"
module rpc_bus_decode (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host pins
  input wire logic cs_n_i,
  input wire logic cmd_sel_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  // Decoded accesses
  output rpc_pkg::rpc_access_t acc_o,
  output logic [7:0] data_o,
  output logic rd_active_o,
  output logic rd_sel_ctl_o
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [7:0] d1_q;
  logic [7:0] d2_q;
  logic wr_end;
  logic rd_end;
  // Completion on the rising strobe edge; both strobes low is inhibited.
  assign wr_end = s3_q[1] == 1'b0 && s2_q[1] == 1'b1 && !s3_q[3] && s3_q[0]; // (R25)
  assign rd_end = s3_q[0] == 1'b0 && s2_q[0] == 1'b1 && !s3_q[3] && s3_q[1]; // (R25)
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      s3_q <= 4'hF;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
    end
    else
    begin
      s1_q <= {cs_n_i, cmd_sel_i, wr_n_i, rd_n_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      d1_q <= data_i;
      d2_q <= d1_q;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_o <= '0;
      data_o <= 8'h00;
    end
    else
    begin
      acc_o.wr_cmd <= wr_end && s3_q[2];
      acc_o.wr_data <= wr_end && !s3_q[2];
      acc_o.rd_ctl <= rd_end && s3_q[2];
      acc_o.rd_prn <= rd_end && !s3_q[2];
      data_o <= d2_q;
    end
  end
  assign rd_active_o = !s2_q[3] && !s2_q[0] && s2_q[1];
  assign rd_sel_ctl_o = s2_q[2];
endmodule

// file: src/rpc_col_buffer.sv
// Column buffer of seven-bit character codes with a write pointer.
// Assumes the controller never requests a write and a blank fill together.
`timescale 1ns/10ps
`include "rpc_defines.svh"
module rpc_col_buffer #(
  parameter int COLS = `RPC_COLS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic blank_i,
  input wire logic wr_i,
  input wire logic [6:0] char_i,
  input wire logic [4:0] ptr_i,
  input wire logic [4:0] rd_idx_i,
  // Read port
  output logic [6:0] char_o
);
  logic [6:0] mem_q [COLS];
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < COLS; i++)
        mem_q[i] <= `RPC_BLANK; // (R7)
    end
    else if (blank_i)
    begin
      for (int i = 0; i < COLS; i++)
        mem_q[i] <= `RPC_BLANK; // (R15)
    end
    else if (wr_i)
    begin
      mem_q[ptr_i] <= char_i;
    end
  end
  assign char_o = mem_q[rd_idx_i];
endmodule

// file: src/rpc_top.sv
// Receipt printer controller: command decoder, status registers and print sequencer.
// Assumes asynchronous host strobes and sensor pins; the printer mechanics sit outside.
`timescale 1ns/10ps
`include "rpc_defines.svh"
module rpc_top #(
  parameter int SOL_LIMIT = `RPC_SOL_CYC,
  parameter int LINE_CYC = `RPC_LINE_CYC,
  parameter int STAMP_CYC = `RPC_STAMP_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host port
  input wire logic cs_n_i,
  input wire logic cmd_sel_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic int_n_o,
  // Printer pins
  input wire logic head_pos0_i,
  input wire logic head_pos1_i,
  input wire logic low_paper_i,
  input wire logic paper_jam_i,
  output rpc_pkg::rpc_drive_t drive_o,
  output logic [6:0] print_char_o,
  output logic [4:0] print_col_o,
  output logic two_dot_o
);
  typedef enum logic [2:0] {RPC_IDLE, RPC_PRINT, RPC_FEED, RPC_STAMP, RPC_RELEASE} rpc_state_t;

  function automatic rpc_pkg::rpc_cmd_t classify(input logic [7:0] b);
    if (b[7:6] == 2'b11)
      classify = rpc_pkg::RPC_C_FAST;
    else if (b[7])
      classify = rpc_pkg::RPC_C_PRINT;
    else if (b[6])
      classify = rpc_pkg::RPC_C_FMT;
    else if (b[5])
      classify = rpc_pkg::RPC_C_INC;
    else if (b[4])
      classify = rpc_pkg::RPC_C_INIT;
    else
      classify = rpc_pkg::RPC_C_STAT;
  endfunction

  rpc_pkg::rpc_access_t acc;
  logic [7:0] wdata;
  logic rd_active;
  logic rd_sel_ctl;
  logic [3:0] sa_q;
  logic [3:0] sb_q;
  logic [4:0] pcol_q;
  logic int_n_q;
  rpc_state_t st_q;
  logic [4:0] ptr_q;
  logic [4:0] model_q;
  logic spacing_q;
  logic iom_q;
  logic psr_q;
  logic wait_rd_q;
  logic merr_q;
  logic int_q;
  logic first_q;
  logic [2:0] sens_q;
  logic [7:0] opr_q;
  logic [4:0] col_q;
  logic [3:0] feeds_q;
  logic [1:0] side_q;
  logic [31:0] tmr_q;
  logic [31:0] sol_q;
  logic blank_q;
  rpc_pkg::rpc_drive_t drv_q;
  logic [7:0] dout_q;
  logic oe_n_q;
  logic [6:0] pchar;
  logic [6:0] pchar_q;
  rpc_pkg::rpc_cmd_t cmd;
  logic busy;
  logic accept;
  logic is_split;
  logic [4:0] inc_sum;
  logic [4:0] ptr_inc;
  logic [4:0] last_col;
  logic [7:0] cst;
  logic [7:0] pst;

  rpc_bus_decode u_bus (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cs_n_i(cs_n_i),
    .cmd_sel_i(cmd_sel_i),
    .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i),
    .data_i(data_i),
    .acc_o(acc),
    .data_o(wdata),
    .rd_active_o(rd_active),
    .rd_sel_ctl_o(rd_sel_ctl)
  );

  rpc_col_buffer #(.COLS(`RPC_COLS)) u_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .blank_i(blank_q),
    .wr_i(acc.wr_data && st_q == RPC_IDLE && !wait_rd_q),
    .char_i(wdata[6:0]), // (R30)
    .ptr_i(ptr_q),
    .rd_idx_i(col_q),
    .char_o(pchar)
  );

  assign cmd = classify(wdata); // (R29)
  assign busy = st_q != RPC_IDLE || blank_q; // (R16)
  assign accept = acc.wr_cmd && !busy && (!wait_rd_q || cmd == rpc_pkg::RPC_C_INIT); // (R9)
  assign is_split = model_q == `RPC_MODEL_SPLIT;
  // The split side boundary wraps the pointer back to the start of its own side.
  assign inc_sum = 5'(ptr_q + wdata[4:0]); // (R13)
  assign ptr_inc = !is_split ? inc_sum :
                   (ptr_q < 5'(`RPC_SPLIT_COLS)) ?
                   5'((ptr_q + wdata[4:0]) % `RPC_SPLIT_COLS) :
                   5'(`RPC_SPLIT_COLS + (ptr_q - `RPC_SPLIT_COLS + wdata[4:0])
                      % `RPC_SPLIT_COLS); // (R14)
  assign last_col = is_split ? 5'(2 * `RPC_SPLIT_COLS - 1) :
                    (model_q == `RPC_MODEL_SLIP) ? 5'(`RPC_SLIP_COLS - 1) :
                    5'(`RPC_LINE_COLS - 1); // (R12)
  assign cst = {5'h00, iom_q, busy || wait_rd_q, psr_q}; // (R1) (R3) (R4)
  assign pst = {sens_q, 4'h0, merr_q}; // (R5) (R6)

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sa_q <= 4'h0;
      sb_q <= 4'h0;
    end
    else
    begin
      sa_q <= {head_pos0_i, head_pos1_i, low_paper_i, paper_jam_i};
      sb_q <= sa_q;
    end
  end

  // Host command and status handling.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_q <= 5'h00;
      model_q <= 5'h00;
      spacing_q <= 1'b0;
      iom_q <= 1'b1;
      psr_q <= 1'b0;
      wait_rd_q <= 1'b0;
      int_q <= 1'b1;
      first_q <= 1'b1;
      sens_q <= 3'h0;
    end
    else
    begin
      if (acc.rd_prn && wait_rd_q)
      begin
        iom_q <= 1'b1; // (R2)
        psr_q <= 1'b0;
        wait_rd_q <= 1'b0;
      end
      if (acc.wr_data && st_q == RPC_IDLE && !wait_rd_q)
      begin
        ptr_q <= 5'(ptr_q + 5'h01); // (R23)
        if (first_q)
          int_q <= 1'b0; // (R27)
        first_q <= 1'b0;
      end
      if (accept)
      begin
        case (cmd)
          rpc_pkg::RPC_C_INIT:
          begin
            ptr_q <= 5'h00; // (R7)
            int_q <= 1'b1;
            first_q <= 1'b1;
            wait_rd_q <= 1'b0;
            psr_q <= 1'b0;
            iom_q <= 1'b1;
          end
          rpc_pkg::RPC_C_STAT:
          begin
            sens_q <= sb_q[3:1]; // (R8)
            wait_rd_q <= 1'b1; // (R9)
            psr_q <= 1'b1; // (R4)
            iom_q <= 1'b0; // (R1)
          end
          rpc_pkg::RPC_C_FMT:
          begin
            model_q <= wdata[4:0]; // (R12)
            spacing_q <= wdata[5] && (wdata[4:0] == `RPC_MODEL_RIB_A ||
                                      wdata[4:0] == `RPC_MODEL_RIB_B); // (R11)
          end
          rpc_pkg::RPC_C_INC:
            ptr_q <= ptr_inc;
          default:
          begin
          end
        endcase
      end
      if (blank_q)
      begin
        ptr_q <= 5'h00;
        int_q <= 1'b1; // (R27)
        first_q <= 1'b1;
      end
    end
  end

  // Print and feed sequencer; drive pins are active low.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= RPC_IDLE;
      opr_q <= 8'h00;
      col_q <= 5'h00;
      feeds_q <= 4'h0;
      side_q <= 2'b00;
      tmr_q <= 32'h0000_0000;
      blank_q <= 1'b0;
      drv_q <= '1;
      pchar_q <= 7'h00;
      pcol_q <= 5'h00;
    end
    else
    begin
      blank_q <= 1'b0;
      case (st_q)
        RPC_IDLE:
        begin
          drv_q <= '1;
          if (accept && cmd == rpc_pkg::RPC_C_PRINT && !merr_q)
          begin
            opr_q <= wdata;
            col_q <= 5'h00;
            tmr_q <= 32'h0000_0000;
            st_q <= RPC_PRINT; // (R15)
          end
          else if (accept && cmd == rpc_pkg::RPC_C_FAST && !merr_q && wdata[3:0] != 4'h0)
          begin
            feeds_q <= wdata[3:0]; // (R21)
            side_q <= is_split ? {!wdata[4], !wdata[5]} : 2'b10; // (R22)
            tmr_q <= 32'h0000_0000;
            opr_q <= 8'h00;
            st_q <= RPC_FEED;
          end
          else if (accept && cmd == rpc_pkg::RPC_C_INIT)
            blank_q <= 1'b1; // (R7)
        end
        RPC_PRINT:
        begin
          drv_q.motor_drive_n <= 1'b0;
          drv_q.solenoid_drives_n <= ~pchar;
          pchar_q <= pchar;
          pcol_q <= col_q;
          drv_q.ribbon_release_n <= !(model_q == `RPC_MODEL_RIB_A ||
                                      model_q == `RPC_MODEL_RIB_B) || opr_q[2]; // (R19)
          if (col_q == last_col)
          begin
            drv_q.solenoid_drives_n <= 7'h7F;
            tmr_q <= 32'h0000_0000;
            feeds_q <= 4'h1;
            if (is_split)
            begin
              side_q <= {!opr_q[4], !opr_q[5]}; // (R17)
              if (!opr_q[1])
                feeds_q <= 4'(`RPC_STAMP_FEEDS); // (R18)
              st_q <= (opr_q[5:4] == 2'b11 && opr_q[1]) ? RPC_IDLE : RPC_FEED;
            end
            else
            begin
              side_q <= 2'b10;
              st_q <= opr_q[5] ? RPC_RELEASE : RPC_FEED; // (R19)
            end
            blank_q <= opr_q[5:4] == 2'b11 && opr_q[1] && is_split;
          end
          else
            col_q <= 5'(col_q + 5'h01);
        end
        RPC_FEED:
        begin
          drv_q.journal_feed_n <= !side_q[1];
          drv_q.receipt_feed_n <= !(side_q[0] || (is_split && !opr_q[1] && opr_q[7]));
          tmr_q <= 32'(tmr_q + 1);
          if (tmr_q == 32'(LINE_CYC - 1))
          begin
            drv_q.journal_feed_n <= 1'b1;
            drv_q.receipt_feed_n <= 1'b1;
            tmr_q <= 32'h0000_0000;
            feeds_q <= 4'(feeds_q - 4'h1);
            if (feeds_q == 4'h1)
              st_q <= (opr_q[7] && is_split && !opr_q[1]) ? RPC_STAMP : RPC_RELEASE;
          end
        end
        RPC_STAMP:
        begin
          drv_q.stamp_drive_n <= 1'b0; // (R18)
          tmr_q <= 32'(tmr_q + 1);
          if (tmr_q == 32'(STAMP_CYC - 1))
          begin
            drv_q.stamp_drive_n <= 1'b1;
            st_q <= RPC_RELEASE;
          end
        end
        default:
        begin
          drv_q.ribbon_release_n <= 1'b1;
          drv_q.motor_drive_n <= 1'b1;
          if (opr_q[7] && model_q == `RPC_MODEL_SLIP && !opr_q[0])
            drv_q.ribbon_release_n <= 1'b0; // (R20)
          blank_q <= opr_q[7]; // (R15)
          st_q <= RPC_IDLE;
        end
      endcase
      if (merr_q)
      begin
        drv_q <= '1; // (R6)
        st_q <= RPC_IDLE;
      end
    end
  end

  // Motor error watchdog: a jam or a solenoid held too long stops the printer.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      merr_q <= 1'b0;
      sol_q <= 32'h0000_0000;
    end
    else
    begin
      if (drv_q.solenoid_drives_n != 7'h7F)
        sol_q <= 32'(sol_q + 1);
      else
        sol_q <= 32'h0000_0000;
      if ((st_q != RPC_IDLE && sb_q[0]) || sol_q >= 32'(SOL_LIMIT))
        merr_q <= 1'b1; // (R28)
      else if (accept && cmd == rpc_pkg::RPC_C_INIT)
        merr_q <= 1'b0; // (R7)
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_q <= 8'h00;
      oe_n_q <= 1'b1;
      int_n_q <= 1'b0;
    end
    else
    begin
      dout_q <= rd_sel_ctl ? cst : pst; // (R25)
      oe_n_q <= !rd_active;
      int_n_q <= !(int_q || merr_q); // (R27) (R28)
    end
  end

  assign data_o = dout_q;
  assign data_oe_n_o = oe_n_q;
  assign int_n_o = int_n_q;
  assign drive_o = drv_q;
  assign print_char_o = pchar_q;
  assign print_col_o = pcol_q;
  assign two_dot_o = spacing_q; // (R11)
endmodule

// file: tb/rpc_top_sva.sv
// Checker for the printer controller: host port, interrupt and printer drive relations.
// Assumes it is bound to rpc_top and sees only the ports of that module.
`timescale 1ns/10ps
module rpc_top_sva #(
  parameter int SOL_LIMIT = 50,
  parameter int LINE_CYC = 16,
  parameter int STAMP_CYC = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host port
  input wire logic cs_n_i,
  input wire logic cmd_sel_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic int_n_o,
  // Printer pins
  input wire logic head_pos0_i,
  input wire logic head_pos1_i,
  input wire logic low_paper_i,
  input wire logic paper_jam_i,
  input wire rpc_pkg::rpc_drive_t drive_o,
  input wire logic [6:0] print_char_o,
  input wire logic [4:0] print_col_o,
  input wire logic two_dot_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // Five clocks of a held read leave room for the three-clock synchroniser.
  sequence ctl_rd;
    (!cs_n_i && cmd_sel_i && !rd_n_i) [*5];
  endsequence
  sequence prn_rd;
    (!cs_n_i && !cmd_sel_i && !rd_n_i) [*5];
  endsequence
  wire jam_hit = paper_jam_i && !drive_o.motor_drive_n;
  wire stopped = drive_o.motor_drive_n && (drive_o.solenoid_drives_n == 7'h7F);
  a_ctl_read_data: assert property (ctl_rd |-> !data_oe_n_o && data_o[7:3] == 5'h00)
    else $error("controller status read malformed");
  a_prn_read_data: assert property (prn_rd |-> !data_oe_n_o && data_o[4:1] == 4'h0)
    else $error("printer status read malformed");
  a_oe_on_read: assert property ($fell(data_oe_n_o) |-> !rd_n_i && !cs_n_i)
    else $error("data bus driven without a read");
  a_oe_released: assert property (rd_n_i [*8] |-> data_oe_n_o)
    else $error("data bus still driven after read");
  a_jam_stops: assert property ($rose(jam_hit) |-> ##[1:10] stopped [*8])
    else $error("motor or solenoids still driven after jam");
  a_jam_int: assert property ($rose(jam_hit) |-> ##[1:10] (!int_n_o) [*8])
    else $error("no interrupt after jam");
  a_sol_needs_motor: assert property (drive_o.solenoid_drives_n != 7'h7F |-> !drive_o.motor_drive_n)
    else $error("solenoid fired with motor off");
  a_data_int_rel: assert property ($rose(wr_n_i) && !cs_n_i && !cmd_sel_i |-> ##[2:8] int_n_o)
    else $error("interrupt kept after data byte");
  c_print: cover property ($fell(drive_o.motor_drive_n));
  c_stamp: cover property ($fell(drive_o.stamp_drive_n));
  c_prn_read: cover property (prn_rd);
endmodule

// file: tb/rpc_host_model.sv
// Host processor model driving the printer port strobes, select and data.
// Assumes the bench calls xfer; pins change only just after mclk_i rises.
`timescale 1ns/10ps
module rpc_host_model (
  // Clock
  input wire logic mclk_i,
  // Port pins
  output logic cs_n_o,
  output logic cmd_sel_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] data_o,
  input wire logic [7:0] data_i
);
  initial
  begin
    cs_n_o = 1'b1;
    cmd_sel_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 8'h5A;
  end
  // Only one strobe is ever low, and the spacing outruns the synchroniser.
  // The bench sends an increment between status request and status read, to check that it is refused.
  // Writes stay inside the column count of the format chosen.
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] wd,
                      output logic [7:0] rv);
    begin
      @(posedge mclk_i);
      cs_n_o <= 1'b0;
      cmd_sel_o <= sel;
      data_o <= wd;
      rd_n_o <= ~rd;
      wr_n_o <= rd;
      repeat (6) @(posedge mclk_i);
      rv = data_i;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      @(posedge mclk_i);
      cs_n_o <= 1'b1;
      // A released bus never keeps its last value.
      data_o <= ~wd;
      repeat (7) @(posedge mclk_i);
    end
  endtask
endmodule

// file: tb/rpc_top_bench.sv
// Self-checking bench for the printer controller with a host model and sensor stimulus.
// Assumes a 100 MHz clock and a shortened solenoid limit.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rpc_top_bench;
  logic mclk_i, rst_i, cs_n, cmd_sel, rd_n, wr_n, oe_n, int_n, jam, two_dot;
  logic [7:0] hdata, rdata, s, c;
  logic [2:0] sens;
  logic [6:0] pchar;
  logic [4:0] pcol;
  rpc_pkg::rpc_drive_t drive;
  logic [6:0] got [32];
  logic [6:0] exp_c [32];
  logic [31:0] seed = 32'hA6EDA3F0;
  int err_total, num_checks, jf, rf, sf, rbf, n, m;
  rpc_top #(.SOL_LIMIT(50)) rpc_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n),
    .cmd_sel_i(cmd_sel), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(hdata), .data_o(rdata),
    .data_oe_n_o(oe_n), .int_n_o(int_n), .head_pos0_i(sens[2]), .head_pos1_i(sens[1]),
    .low_paper_i(sens[0]), .paper_jam_i(jam), .drive_o(drive), .print_char_o(pchar),
    .print_col_o(pcol), .two_dot_o(two_dot));
  rpc_host_model rpc_host_model_i (.mclk_i(mclk_i), .cs_n_o(cs_n), .cmd_sel_o(cmd_sel),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(hdata), .data_i(rdata));
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Columns are taken as printed while the motor runs.
  always @(posedge mclk_i)
  begin
    if (drive.motor_drive_n === 1'b0) got[pcol] <= pchar;
  end
  always @(negedge drive.journal_feed_n) jf++;
  always @(negedge drive.receipt_feed_n) rf++;
  always @(negedge drive.stamp_drive_n) sf++;
  always @(negedge drive.ribbon_release_n) rbf++;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic sel, input logic [7:0] v);
    logic [7:0] d;
    rpc_host_model_i.xfer(sel, 1'b0, v, d);
  endtask
  task automatic rd(input logic sel, output logic [7:0] v);
    rpc_host_model_i.xfer(sel, 1'b1, 8'h00, v);
  endtask
  task automatic fmt(input logic [7:0] f);
    wr(1'b1, 8'h10);
    wr(1'b1, f);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    s = 8'hFF;
    while (s[1] !== 1'b0 && k < 300)
    begin
      rd(1'b1, s);
      k++;
    end
    `CHK("busy_clear", 1'b0, s[1])
  endtask
  task automatic run(input logic [7:0] cmd, input int ej, input int er, input int es);
    jf = 0;
    rf = 0;
    sf = 0;
    rbf = 0;
    for (int i = 0; i < 32; i++) got[i] = 7'h00;
    wr(1'b1, cmd);
    rd(1'b1, s);
    `CHK("busy_set", 1'b1, s[1])
    wait_idle();
    `CHK("journal_feeds", ej, jf)
    `CHK("receipt_feeds", er, rf)
    `CHK("stamps", es, sf)
    $display("test command %h done", cmd);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    err_total++;
    end_of_test();
  end
  initial
  begin
    rst_i = 1'b1;
    sens = 3'h0;
    jam = 1'b0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(1'b1, s);
    `CHK("dir_reset", 1'b1, s[2])
    `CHK("int_ready", 1'b0, int_n)
    fmt(8'h7E);
    `CHK("two_dot_ribbon", 1'b1, two_dot)
    fmt(8'h6B);
    `CHK("two_dot_split", 1'b0, two_dot)
    fmt(8'h5B);
    repeat (3)
    begin
      c = xs();
      sens <= c[2:0];
      wr(1'b1, 8'h00);
      sens <= ~c[2:0];
      rd(1'b1, s);
      `CHK("dir_wait", 1'b0, s[2])
      `CHK("status_ready", 1'b1, s[0])
      wr(1'b1, 8'h23);
      rd(1'b0, s);
      `CHK("prn_status", {c[2:0], 5'h00}, s)
      rd(1'b1, s);
      `CHK("dir_after", 1'b1, s[2])
      `CHK("status_gone", 1'b0, s[0])
    end
    $display("test status done");
    n = 5 + xs() % 20;
    for (int i = 0; i < 32; i++) exp_c[i] = 7'h20;
    for (int i = 0; i < n; i++)
    begin
      c = xs();
      exp_c[i] = c[6:0];
      wr(1'b0, c);
    end
    wr(1'b1, 8'h23);
    c = xs();
    exp_c[n + 3] = c[6:0];
    wr(1'b0, c);
    run(8'hB2, 0, 0, 0);
    for (int i = 0; i < 31; i++) `CHK("column", exp_c[i], got[i])
    run(8'hB2, 0, 0, 0);
    for (int i = 0; i < 31; i++) `CHK("blank", 7'h20, got[i])
    fmt(8'h4B);
    wr(1'b1, 8'h2A);
    wr(1'b1, 8'h26);
    c = xs();
    wr(1'b0, c);
    run(8'hB2, 0, 0, 0);
    `CHK("split_wrap", c[6:0], got[2])
    for (int k = 0; k < 4; k++) run(8'h82 | (k << 4), int'(k == 0 || k == 2), int'(k < 2), 0);
    run(8'hB0, 0, 11, 1);
    for (int k = 0; k < 3; k++)
    begin
      m = 2 + xs() % 14;
      run(8'hC0 | (k << 4) | m, (k != 1) ? m : 0, (k != 2) ? m : 0, 0);
    end
    fmt(8'h5E);
    run(8'h90, 1, 0, 0);
    `CHK("ribbon_red", 1'b1, rbf != 0)
    run(8'hB4, 0, 0, 0);
    `CHK("ribbon_black", 1'b0, rbf != 0)
    fmt(8'h57);
    run(8'hB2, 0, 0, 0);
    `CHK("slip_release", 1'b1, rbf != 0)
    run(8'hB3, 0, 0, 0);
    `CHK("slip_kept", 1'b0, rbf != 0)
    fmt(8'h5B);
    wr(1'b1, 8'hB3);
    jam <= 1'b1;
    repeat (20) @(posedge mclk_i);
    jam <= 1'b0;
    `CHK("jam_int", 1'b0, int_n)
    wait_idle();
    wr(1'b1, 8'h00);
    rd(1'b0, s);
    `CHK("motor_error", 1'b1, s[0])
    wr(1'b1, 8'h10);
    wr(1'b1, 8'h00);
    rd(1'b0, s);
    `CHK("error_cleared", 1'b0, s[0])
    wr(1'b0, 8'h41);
    wr(1'b1, 8'h10);
    run(8'hB2, 0, 0, 0);
    `CHK("init_blank", 7'h20, got[0])
    $display("test jam done");
    end_of_test();
  end
endmodule
bind rpc_top rpc_top_sva #(.SOL_LIMIT(SOL_LIMIT), .LINE_CYC(LINE_CYC), .STAMP_CYC(STAMP_CYC))
  rpc_top_sva_i (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .cmd_sel_i(cmd_sel_i),
  .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_i(data_i), .data_o(data_o),
  .data_oe_n_o(data_oe_n_o), .int_n_o(int_n_o), .head_pos0_i(head_pos0_i),
  .head_pos1_i(head_pos1_i), .low_paper_i(low_paper_i), .paper_jam_i(paper_jam_i),
  .drive_o(drive_o), .print_char_o(print_char_o), .print_col_o(print_col_o),
  .two_dot_o(two_dot_o));
